// ===== logic/flash_self_program_map.sv
// Self-programming sequencer: signature reads, store commands,
// timed flash writes and section map. Assumes CPU on the same clk.
`timescale 1ns/100ps
`include "flash_self_program_params.svh"
module flash_self_program_map
#(
   parameter int PROG_CYC = 80000,
   parameter logic [7:0] ID_BYTE1 = 8'h5A, // Arbitrary value
   parameter logic [7:0] ID_BYTE2 = 8'hA5, // Arbitrary value
   parameter logic [7:0] ID_BYTE3 = 8'h3C  // Arbitrary value
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic por_b,
   input wire logic [1:0] boot_size,
   input wire logic variant_32k,
   input wire logic [7:0] rc_cal_byte,
   input wire logic ctrl_wr,
   input wire logic sig_sel_wr,
   input wire logic prog_en_wr,
   input wire logic reenable_wr,
   input wire logic [1:0] op_wr,
   input wire logic [15:0] z_ptr,
   input wire logic load_instr,
   input wire logic store_instr,
   input wire logic [15:0] flash_word,
   output logic [7:0] load_data,
   output logic signature_read_select,
   output logic self_prog_enable,
   output logic region_busy_flag,
   output logic flash_busy,
   output logic flash_erase,
   output logic flash_write,
   output logic buf_fill,
   output logic buf_clear,
   output logic [7:0] page_index,
   output logic [5:0] word_in_page,
   output logic [13:0] flash_addr,
   output logic [13:0] boot_start,
   output logic [13:0] app_end,
   output logic [13:0] flash_end,
   output logic [13:0] no_concurrent_read_region_start
);
   localparam longint PROG_MIN_CYC =
      (longint'(`PROG_MIN_NS) * `CLK_HZ + 64'd999999999) / 64'd1000000000;
   localparam longint PROG_MAX_CYC =
      (longint'(`PROG_MAX_NS) * `CLK_HZ) / 64'd1000000000;

   flash_self_program_pkg::seq_state_e state_q, state_d;
   flash_self_program_pkg::prog_op_e op_q, op_d;
   logic [2:0] win_q, win_d;
   logic [16:0] prog_cnt_q, prog_cnt_d;
   logic sig_q, sig_d, en_q, en_d, busy_q, busy_d;
   logic [7:0] data_q, data_d;
   logic [7:0] page_q, page_d;
   logic erase_q, erase_d, write_q, write_d;
   logic fill_d, clr_d;
   logic rst_meta_q, rst_sync_q;

   // Section map straps
   flash_section_map u_map
   (
      .boot_size(boot_size),
      .variant_32k(variant_32k),
      .boot_start(boot_start),
      .app_end(app_end),
      .flash_end(flash_end),
      .no_concurrent_read_region_start(no_concurrent_read_region_start)
   );

   function automatic logic [7:0] sig_byte(input logic [15:0] a,
                                           input logic [7:0] cal);
      begin
         unique case (a)
            `SIG_ADDR_ID1: sig_byte = ID_BYTE1;
            `SIG_ADDR_ID2: sig_byte = ID_BYTE2;
            `SIG_ADDR_ID3: sig_byte = ID_BYTE3;
            `SIG_ADDR_CAL: sig_byte = cal;
            default: sig_byte = 8'hFF; // Reserved addresses
         endcase
      end
   endfunction : sig_byte

   always_comb
   begin
      state_d = state_q;
      op_d = op_q;
      win_d = win_q;
      prog_cnt_d = prog_cnt_q;
      sig_d = sig_q;
      en_d = en_q;
      busy_d = busy_q;
      data_d = data_q;
      page_d = page_q;
      erase_d = erase_q;
      write_d = write_q;
      fill_d = 1'b0;
      clr_d = 1'b0;
      if (load_instr)
      begin
         if (sig_q && en_q && state_q == flash_self_program_pkg::ST_SIG_ARMED)
            data_d = sig_byte(z_ptr, rc_cal_byte);
         else if (z_ptr[0])
            data_d = flash_word[15:8];
         else
            data_d = flash_word[7:0];
      end
      unique case (state_q)
         flash_self_program_pkg::ST_IDLE:
         begin
            if (ctrl_wr && prog_en_wr && sig_sel_wr)
            begin
               sig_d = 1'b1;
               en_d = 1'b1;
               win_d = 3'({1'b0, `SIG_WINDOW_CYC});
               state_d = flash_self_program_pkg::ST_SIG_ARMED;
            end
            else if (ctrl_wr && prog_en_wr)
            begin
               en_d = 1'b1;
               op_d = flash_self_program_pkg::prog_op_e'(op_wr);
               win_d = `STORE_WINDOW_CYC;
               state_d = flash_self_program_pkg::ST_STORE_ARMED;
            end
         end
         flash_self_program_pkg::ST_SIG_ARMED:
         begin
            // Auto clear on read or timeout
            if (load_instr || win_q == 3'h1)
            begin
               sig_d = 1'b0;
               en_d = 1'b0;
               state_d = flash_self_program_pkg::ST_IDLE;
            end
            else
               win_d = win_q - 3'h1;
         end
         flash_self_program_pkg::ST_STORE_ARMED:
         begin
            if (store_instr)
            begin
               page_d = z_ptr[`PAGE_MSB:`PAGE_LSB];
               if (reenable_wr)
               begin
                  busy_d = 1'b0;
                  clr_d = 1'b1;
                  en_d = 1'b0;
                  state_d = flash_self_program_pkg::ST_IDLE;
               end
               else if (op_q == flash_self_program_pkg::OP_FILL)
               begin
                  fill_d = 1'b1;
                  en_d = 1'b0;
                  state_d = flash_self_program_pkg::ST_IDLE;
               end
               else
               begin
                  erase_d = op_q == flash_self_program_pkg::OP_ERASE;
                  write_d = op_q != flash_self_program_pkg::OP_ERASE;
                  // Lock write leaves whole flash readable
                  if (op_q != flash_self_program_pkg::OP_LOCK)
                     busy_d = 1'b1;
                  prog_cnt_d = 17'(PROG_CYC);
                  state_d = flash_self_program_pkg::ST_PROGRAM;
               end
            end
            else if (win_q == 3'h1)
            begin
               en_d = 1'b0;
               state_d = flash_self_program_pkg::ST_IDLE;
            end
            else
               win_d = win_q - 3'h1;
         end
         flash_self_program_pkg::ST_PROGRAM:
         begin
            if (prog_cnt_q == 17'h00001)
            begin
               erase_d = 1'b0;
               write_d = 1'b0;
               en_d = 1'b0;
               clr_d = op_q == flash_self_program_pkg::OP_WRITE;
               state_d = flash_self_program_pkg::ST_IDLE;
            end
            else
               prog_cnt_d = prog_cnt_q - 17'h00001;
         end
      endcase
   end

   // Reset pin is not timed to clk; only the second stage is read
   always_ff @(posedge clk or negedge por_b)
   begin
      if (!por_b)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= rst_b;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Reset during a program cycle lets it finish; only power loss aborts
   always_ff @(posedge clk or negedge por_b)
   begin
      if (!por_b)
      begin
         state_q <= flash_self_program_pkg::ST_IDLE;
         op_q <= flash_self_program_pkg::OP_FILL;
         win_q <= 3'h0;
         prog_cnt_q <= 17'h00000;
         sig_q <= 1'b0;
         en_q <= 1'b0;
         busy_q <= 1'b0;
         data_q <= 8'h00;
         page_q <= 8'h00;
         erase_q <= 1'b0;
         write_q <= 1'b0;
         buf_fill <= 1'b0;
         buf_clear <= 1'b0;
      end
      else if (!rst_sync_q && state_q != flash_self_program_pkg::ST_PROGRAM)
      begin
         state_q <= flash_self_program_pkg::ST_IDLE;
         sig_q <= 1'b0;
         en_q <= 1'b0;
         busy_q <= 1'b0;
         buf_fill <= 1'b0;
         buf_clear <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         op_q <= op_d;
         win_q <= win_d;
         prog_cnt_q <= prog_cnt_d;
         sig_q <= sig_d;
         en_q <= en_d;
         busy_q <= busy_d;
         data_q <= data_d;
         page_q <= page_d;
         erase_q <= erase_d;
         write_q <= write_d;
         buf_fill <= fill_d;
         buf_clear <= clr_d;
      end
   end

   assign load_data = data_q;
   assign signature_read_select = sig_q;
   assign self_prog_enable = en_q;
   assign region_busy_flag = busy_q;
   assign flash_busy = state_q == flash_self_program_pkg::ST_PROGRAM;
   assign flash_erase = erase_q;
   assign flash_write = write_q;
   assign page_index = page_q;
   assign word_in_page = z_ptr[`WORD_MSB:`WORD_LSB];
   assign flash_addr = {page_q[7:0], z_ptr[`WORD_MSB:`WORD_LSB]};

   a_prog_time: assert property (@(posedge clk) disable iff (!por_b)
      $rose(flash_busy) |-> flash_busy [*8])
      else $error("Program cycle ended too early");
   a_prog_bound: assert property (@(posedge clk) disable iff (!por_b)
      1'b1 |-> (longint'(PROG_CYC) >= PROG_MIN_CYC
                && longint'(PROG_CYC) <= PROG_MAX_CYC))
      else $error("Program count outside window");
   a_sig_clear: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(signature_read_select) |-> ##[1:3] !signature_read_select)
      else $error("Signature select did not clear");
   a_sig_data: assert property (@(posedge clk) disable iff (!rst_b)
      (signature_read_select && load_instr && z_ptr == `SIG_ADDR_CAL
       && state_q == flash_self_program_pkg::ST_SIG_ARMED)
      |=> load_data == $past(rc_cal_byte))
      else $error("Calibration byte not returned");
   a_plain_load: assert property (@(posedge clk) disable iff (!rst_b)
      (!signature_read_select && load_instr && !z_ptr[0])
      |=> load_data == $past(flash_word[7:0]))
      else $error("Ordinary load data wrong");
   a_odd_byte: assert property (@(posedge clk) disable iff (!rst_b)
      (!signature_read_select && load_instr && z_ptr[0])
      |=> load_data == $past(flash_word[15:8]))
      else $error("High byte not selected");
   a_busy_clear: assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == flash_self_program_pkg::ST_STORE_ARMED && store_instr
       && reenable_wr) |=> !region_busy_flag)
      else $error("Busy flag not cleared");
   a_busy_hold: assert property (@(posedge clk) disable iff (!por_b)
      (flash_busy && op_q != flash_self_program_pkg::OP_LOCK)
      |-> region_busy_flag)
      else $error("Busy flag dropped while programming");
   a_boot_map: assert property (@(posedge clk) disable iff (!rst_b)
      app_end + 14'h0001 == boot_start && boot_start >= no_concurrent_read_region_start
      && flash_end - boot_start
         == 14'((15'h0100 << (2'h3 - boot_size)) - 15'h0001))
      else $error("Boot map inconsistent");
   a_reset_keep: assert property (@(posedge clk) disable iff (!por_b)
      (flash_busy && !rst_sync_q && prog_cnt_q > 17'h00001) |=> flash_busy)
      else $error("Reset aborted a write");
endmodule : flash_self_program_map

// ===== logic/flash_self_program_params.svh
// Constants for the flash self-programming map block.
// Included by the design modules; definitions only.
`ifndef FLASH_SELF_PROGRAM_PARAMS_SVH
`define FLASH_SELF_PROGRAM_PARAMS_SVH

`define SIG_ADDR_ID1 16'h0000
`define SIG_ADDR_CAL 16'h0001
`define SIG_ADDR_ID2 16'h0002
`define SIG_ADDR_ID3 16'h0004
`define SIG_WINDOW_CYC 2'h3
`define STORE_WINDOW_CYC 3'h4
`define CLK_HZ 20000000
`define PROG_MIN_NS 3700000
`define PROG_MAX_NS 4500000
`define BOOT_START_32K_11 14'h3F00
`define BOOT_START_32K_10 14'h3E00
`define BOOT_START_32K_01 14'h3C00
`define BOOT_START_32K_00 14'h3800
`define BOOT_START_16K_11 14'h1F00
`define BOOT_START_16K_10 14'h1E00
`define BOOT_START_16K_01 14'h1C00
`define BOOT_START_16K_00 14'h1800
`define FLASH_END_32K 14'h3FFF
`define FLASH_END_16K 14'h1FFF
`define NO_CONCURRENT_READ_REGION_START_32K 14'h3800
`define NO_CONCURRENT_READ_REGION_START_16K 14'h1800
`define PAGE_LSB 7
`define PAGE_MSB 14
`define WORD_LSB 1
`define WORD_MSB 6

`endif

// ===== logic/flash_self_program_pkg.sv
// Types for the flash self-programming map block.
// Constants live in the params header.
package flash_self_program_pkg;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_SIG_ARMED = 2'b01,
      ST_STORE_ARMED = 2'b11,
      ST_PROGRAM = 2'b10
   } seq_state_e;
   typedef enum logic [1:0]
   {
      OP_FILL = 2'h0,
      OP_ERASE = 2'h1,
      OP_WRITE = 2'h2,
      OP_LOCK = 2'h3
   } prog_op_e;
endpackage : flash_self_program_pkg

// ===== logic/flash_section_map.sv
// Combinational map of boot and read-while-write boundaries.
// Assumes boot size and variant are static straps after reset.
`timescale 1ns/100ps
`include "flash_self_program_params.svh"
module flash_section_map
(
   input wire logic [1:0] boot_size,
   input wire logic variant_32k,
   output logic [13:0] boot_start,
   output logic [13:0] app_end,
   output logic [13:0] flash_end,
   output logic [13:0] no_concurrent_read_region_start
);
   always_comb
   begin
      unique case ({variant_32k, boot_size})
         3'b111: boot_start = `BOOT_START_32K_11;
         3'b110: boot_start = `BOOT_START_32K_10;
         3'b101: boot_start = `BOOT_START_32K_01;
         3'b100: boot_start = `BOOT_START_32K_00;
         3'b011: boot_start = `BOOT_START_16K_11;
         3'b010: boot_start = `BOOT_START_16K_10;
         3'b001: boot_start = `BOOT_START_16K_01;
         3'b000: boot_start = `BOOT_START_16K_00;
      endcase
      app_end = boot_start - 14'h0001;
      flash_end = variant_32k ? `FLASH_END_32K : `FLASH_END_16K;
      // Fixed whatever the boot size
      no_concurrent_read_region_start = variant_32k ? `NO_CONCURRENT_READ_REGION_START_32K : `NO_CONCURRENT_READ_REGION_START_16K;
   end
endmodule : flash_section_map

// ===== sim/cpu_core_model.sv
// CPU core model: control writes, loads, stores and flash contents.
// Assumes its tasks are entered at a falling clock edge.
`timescale 1ns/100ps
module cpu_core_model
(
   input wire logic clk,
   output logic ctrl_wr,
   output logic sig_sel_wr,
   output logic prog_en_wr,
   output logic reenable_wr,
   output logic [1:0] op_wr,
   output logic [15:0] z_ptr,
   output logic load_instr,
   output logic store_instr,
   output logic [15:0] flash_word
);
   initial
   begin
      {ctrl_wr, sig_sel_wr, prog_en_wr, reenable_wr} = 4'h0;
      {load_instr, store_instr, op_wr} = 4'h0;
      z_ptr = 16'h0000;
   end
   // Distinct pattern per word, so a stale or wrong word shows
   assign flash_word = {2'h0, z_ptr[14:1]} ^ 16'hA5C3;
   task automatic load(input logic [15:0] z);
      z_ptr = z;
      load_instr = 1'b1;
      @(negedge clk) load_instr = 1'b0;
      // Idle edge so back-to-back calls never re-raise the strobe at once
      @(negedge clk);
   endtask : load
   // Kind 0 nothing, 1 load, 2 store after gap idle cycles
   task automatic cmd(input logic sig, input logic re, input logic [1:0] op,
      input logic [15:0] z, input int gap, input int kind);
      logic [15:0] zz;
      zz = z;
      if (kind == 2)
      begin
         zz[0] = 1'b0;
         if (op == 2'h2)
            zz[6:1] = 6'h00;
      end
      z_ptr = zz;
      {sig_sel_wr, prog_en_wr, reenable_wr, op_wr} = {sig, 1'b1, re, op};
      ctrl_wr = 1'b1;
      @(negedge clk) ctrl_wr = 1'b0;
      // Gaps above three are only used to provoke a refusal
      repeat (gap) @(negedge clk);
      if (kind == 0)
         return;
      load_instr = (kind == 1);
      store_instr = (kind == 2);
      @(negedge clk) {load_instr, store_instr} = 2'h0;
   endtask : cmd
endmodule : cpu_core_model

// ===== sim/flash_self_program_map_test.sv
// Self-checking bench for the flash self-programming map block.
// Assumes the CPU model drives all command inputs at falling edges.
`timescale 1ns/100ps
module flash_self_program_map_test;
   localparam logic [7:0] ID1 = 8'h11; // Arbitrary value
   localparam logic [7:0] ID2 = 8'h22; // Arbitrary value
   localparam logic [7:0] ID3 = 8'h33; // Arbitrary value
   logic clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, variant_32k = 1'b0;
   logic [1:0] boot_size = 2'h0;
   logic [7:0] rc_cal_byte = 8'h00;
   logic ctrl_wr, sig_sel_wr, prog_en_wr, reenable_wr, load_instr;
   logic store_instr;
   logic [1:0] op_wr;
   logic [15:0] z_ptr, flash_word, z;
   logic [7:0] load_data, page_index;
   logic signature_read_select, self_prog_enable, region_busy_flag;
   logic flash_busy, flash_erase, flash_write, buf_fill, buf_clear;
   logic [5:0] word_in_page;
   logic [13:0] flash_addr, boot_start, app_end, flash_end, no_concurrent_read_region_start, bexp;
   int err_count = 0, checks = 0, cycle_count = 0, n;
   logic [15:0] sig_addr [5] = '{16'h0, 16'h1, 16'h2, 16'h4, 16'h3};
   logic [7:0] sig_exp [5];
   always #25 clk = ~clk;
   flash_self_program_map #(.ID_BYTE1(ID1), .ID_BYTE2(ID2),
      .ID_BYTE3(ID3)) dut_u (.clk(clk), .rst_b(rst_b), .por_b(por_b),
      .boot_size(boot_size), .variant_32k(variant_32k),
      .rc_cal_byte(rc_cal_byte), .ctrl_wr(ctrl_wr),
      .sig_sel_wr(sig_sel_wr), .prog_en_wr(prog_en_wr),
      .reenable_wr(reenable_wr), .op_wr(op_wr), .z_ptr(z_ptr),
      .load_instr(load_instr), .store_instr(store_instr),
      .flash_word(flash_word), .load_data(load_data),
      .signature_read_select(signature_read_select),
      .self_prog_enable(self_prog_enable),
      .region_busy_flag(region_busy_flag), .flash_busy(flash_busy),
      .flash_erase(flash_erase), .flash_write(flash_write),
      .buf_fill(buf_fill), .buf_clear(buf_clear), .page_index(page_index),
      .word_in_page(word_in_page), .flash_addr(flash_addr),
      .boot_start(boot_start), .app_end(app_end), .flash_end(flash_end),
      .no_concurrent_read_region_start(no_concurrent_read_region_start));
   cpu_core_model cpu_u (.clk(clk), .ctrl_wr(ctrl_wr),
      .sig_sel_wr(sig_sel_wr), .prog_en_wr(prog_en_wr),
      .reenable_wr(reenable_wr), .op_wr(op_wr), .z_ptr(z_ptr),
      .load_instr(load_instr), .store_instr(store_instr),
      .flash_word(flash_word));
   function automatic logic [7:0] flash_exp(input logic [15:0] a);
      logic [15:0] w;
      w = {2'h0, a[14:1]} ^ 16'hA5C3;
      return a[0] ? w[15:8] : w[7:0];
   endfunction : flash_exp
   function automatic logic [13:0] boot_exp(input logic [1:0] bs,
      input logic v);
      logic [14:0] top;
      top = v ? 15'h4000 : 15'h2000;
      return 14'(top - (15'h0100 << (2'h3 - bs)));
   endfunction : boot_exp
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic por_abort();
      por_b = 1'b0;
      @(negedge clk);
      check(flash_busy, 1'b0);
      por_b = 1'b1;
      // Two edges for the reset synchroniser to let go
      repeat (2) @(negedge clk);
   endtask : por_abort
   // Ceiling covers one full-length erase plus the short tests
   always @(posedge clk)
   begin
      cycle_count++;
      if (cycle_count == 95000)
      begin
         err_count++;
         complete_run();
      end
   end
   initial
   begin
      void'($urandom(78));
      // Straps swept while held in reset, so they stay static in use
      for (int i = 0; i < 10; i++)
      begin
         if (i[0])
            #1;
         else
            @(negedge clk);
         {variant_32k, boot_size} = 3'(i);
         #1;
         bexp = boot_exp(boot_size, variant_32k);
         check(boot_start, bexp);
         check(app_end, bexp - 14'h1);
         check(flash_end, variant_32k ? 14'h3FFF : 14'h1FFF);
         check(no_concurrent_read_region_start, variant_32k ? 14'h3800 : 14'h1800);
      end
      // Six edges in reset, then two more for the synchroniser
      @(negedge clk) {por_b, rst_b} = 2'h3;
      repeat (2) @(negedge clk);
      $display("test section map done");
      for (int k = 0; k < 5; k++)
      begin
         rc_cal_byte = 8'($urandom);
         sig_exp = '{ID1, rc_cal_byte, ID2, ID3, 8'hFF};
         cpu_u.cmd(1'b1, 1'b0, 2'h0, sig_addr[k], 0, 1);
         check(load_data, sig_exp[k]);
         check({signature_read_select, self_prog_enable}, 2'h0);
      end
      cpu_u.cmd(1'b1, 1'b0, 2'h0, 16'h0001, 0, 0);
      check({signature_read_select, self_prog_enable}, 2'h3);
      repeat (4) @(negedge clk);
      check({signature_read_select, self_prog_enable}, 2'h0);
      for (int k = 0; k < 20; k++)
      begin
         z = 16'($urandom);
         cpu_u.load(z);
         check(load_data, flash_exp(z));
      end
      $display("test signature and loads done");
      z = 16'($urandom);
      cpu_u.cmd(1'b0, 1'b0, 2'h0, z, 0, 2);
      check({buf_fill, flash_busy}, 2'h2);
      check(word_in_page, z[6:1]);
      cpu_u.cmd(1'b0, 1'b0, 2'h1, z, 8, 2);
      check({flash_busy, self_prog_enable}, 2'h0);
      cpu_u.cmd(1'b0, 1'b0, 2'h2, z, 0, 2);
      check({flash_write, flash_erase, region_busy_flag}, 3'h5);
      check({page_index, word_in_page}, {z[14:7], 6'h00});
      check(flash_addr, {z[14:7], 6'h00});
      por_abort();
      cpu_u.cmd(1'b0, 1'b0, 2'h3, z, 0, 2);
      check({flash_busy, region_busy_flag}, 2'h2);
      por_abort();
      $display("test store commands done");
      cpu_u.cmd(1'b0, 1'b0, 2'h1, z, 0, 2);
      check({flash_erase, region_busy_flag}, 2'h3);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      n = 3;
      while (flash_busy === 1'b1 && n < 95000)
      begin
         @(negedge clk);
         n++;
      end
      check(n >= 74000 && n <= 90000, 1'b1);
      check({region_busy_flag, self_prog_enable}, 2'h2);
      cpu_u.cmd(1'b0, 1'b1, 2'h0, z, 0, 2);
      check({region_busy_flag, buf_clear}, 2'h1);
      @(negedge clk);
      check({region_busy_flag, buf_clear}, 2'h0);
      $display("test erase across reset done");
      complete_run();
   end
endmodule : flash_self_program_map_test
